// file: rtl/dmrt_pkg.sv
/*
  package for the dual mode reload timer: register offsets, control field
  positions, reset values and prescale counts.
  assumes an 8-bit special function register port on the system clock.
*/
package dmrt_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] DMRT_ADDR_CONTROL = 8'h91;
  localparam logic [7:0] DMRT_ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] DMRT_ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] DMRT_ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] DMRT_ADDR_COUNT_HIGH = 8'h95;

  // ==========================================================
  // control field positions and reset values
  localparam int DMRT_BIT_HIGH_OVF = 7;
  localparam int DMRT_BIT_LOW_OVF = 6;
  localparam int DMRT_BIT_LOW_IEN = 5;
  localparam int DMRT_BIT_CAPTURE = 4;
  localparam int DMRT_BIT_SPLIT = 3;
  localparam int DMRT_BIT_RUN = 2;
  localparam int DMRT_BIT_UNUSED = 1;
  localparam int DMRT_BIT_EXT_SEL = 0;
  localparam logic [7:0] DMRT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DMRT_BYTE_RESET = 8'h00;
  localparam logic [7:0] DMRT_BYTE_ALL_ONES = 8'hFF;

  // ==========================================================
  // prescale counts
  localparam int DMRT_SYS_DIV = 12;
  localparam int DMRT_EXT_DIV = 8;
  localparam logic [3:0] DMRT_SYS_DIV_LAST = 4'(DMRT_SYS_DIV - 1);

  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_interrupt_enable;
    logic lfo_capture_enable;
    logic split_mode;
    logic run_control;
    logic unused;
    logic external_clock_select;
  } dmrt_control_t;

endpackage : dmrt_pkg

// file: rtl/dmrt_timer.sv
/*
  dual mode reload timer: one 16-bit auto-reload counter or two 8-bit ones,
  with per-byte clock choice, overflow flags, lfo capture and interrupt request.
  assumes sfr port signals synchronous to clk; ext_div8_clk is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module dmrt_timer
  import dmrt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic high_byte_clock_mode,
  input wire logic low_byte_clock_mode,
  input wire logic ext_div8_clk,
  input wire logic lfo_out,
  input wire logic extended_interrupt_enable,
  output logic timer_irq
);

  // ==========================================================
  // registers
  dmrt_control_t ctrl_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic [7:0] count_low_reg;
  logic [7:0] count_high_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic [3:0] div12_reg;
  logic tick12_reg;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic lfo_prev_reg;
  logic cap_pend_reg;

  logic wr_ctrl;
  logic wr_rll;
  logic wr_rlh;
  logic wr_cl;
  logic wr_ch;
  logic ext_tick;
  logic slow_tick;
  logic tick_low;
  logic tick_high;
  logic step_low;
  logic step_high;
  logic wrap_low;
  logic wrap_high;
  logic wrap_full;
  logic cap_evt;

  assign wr_ctrl = sfr_wr && (sfr_addr == DMRT_ADDR_CONTROL);
  assign wr_rll = sfr_wr && (sfr_addr == DMRT_ADDR_RELOAD_LOW);
  assign wr_rlh = sfr_wr && (sfr_addr == DMRT_ADDR_RELOAD_HIGH);
  assign wr_cl = sfr_wr && (sfr_addr == DMRT_ADDR_COUNT_LOW);
  assign wr_ch = sfr_wr && (sfr_addr == DMRT_ADDR_COUNT_HIGH);

  // ==========================================================
  // clock sources
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div12_reg <= 4'h0;
      tick12_reg <= 1'b0;
    end else begin
      tick12_reg <= (div12_reg == DMRT_SYS_DIV_LAST);
      div12_reg <= (div12_reg == DMRT_SYS_DIV_LAST) ? 4'h0 : div12_reg + 4'h1;
    end
  end

  // edge detect looks at the second and third stages, never the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_div8_clk;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  assign ext_tick = ext_sync_reg && !ext_prev_reg;
  assign slow_tick = ctrl_reg.external_clock_select ? ext_tick : tick12_reg;
  assign tick_low = low_byte_clock_mode ? 1'b1 : slow_tick;
  assign tick_high = high_byte_clock_mode ? 1'b1 : slow_tick;

  // ==========================================================
  // counting
  // 16-bit mode takes its tick from the low byte selection
  assign step_low = ctrl_reg.split_mode ? tick_low : (ctrl_reg.run_control && tick_low);
  assign wrap_low = step_low && (count_low_reg == DMRT_BYTE_ALL_ONES);
  assign step_high = ctrl_reg.split_mode ? (ctrl_reg.run_control && tick_high) : wrap_low;
  assign wrap_high = step_high && (count_high_reg == DMRT_BYTE_ALL_ONES);
  assign wrap_full = !ctrl_reg.split_mode && wrap_high;

  // software write wins over a count step in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_low_reg <= DMRT_BYTE_RESET;
    end else if (wr_cl) begin
      count_low_reg <= sfr_wdata;
    end else if (wrap_low && (ctrl_reg.split_mode || wrap_full)) begin
      // a lone low wrap in 16-bit mode is a carry, so it falls through to the step
      count_low_reg <= reload_low_reg;
    end else if (step_low) begin
      count_low_reg <= count_low_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_high_reg <= DMRT_BYTE_RESET;
    end else if (wr_ch) begin
      count_high_reg <= sfr_wdata;
    end else if (wrap_high) begin
      count_high_reg <= reload_high_reg;
    end else if (step_high) begin
      count_high_reg <= count_high_reg + 8'h01;
    end
  end

  // ==========================================================
  // capture on lfo rising edge
  assign cap_evt = lfo_out && !lfo_prev_reg && ctrl_reg.lfo_capture_enable
    && extended_interrupt_enable;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfo_prev_reg <= 1'b0;
    end else begin
      lfo_prev_reg <= lfo_out;
    end
  end

  // capture beats a software write to the reload pair
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_low_reg <= DMRT_BYTE_RESET;
      reload_high_reg <= DMRT_BYTE_RESET;
    end else if (cap_evt) begin
      reload_low_reg <= count_low_reg;
      reload_high_reg <= count_high_reg;
    end else begin
      if (wr_rll) begin
        reload_low_reg <= sfr_wdata;
      end
      if (wr_rlh) begin
        reload_high_reg <= sfr_wdata;
      end
    end
  end

  // capture request held until software writes the control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_pend_reg <= 1'b0;
    end else begin
      cap_pend_reg <= cap_evt || (cap_pend_reg && !wr_ctrl);
    end
  end

  // ==========================================================
  // control register, flags set by hardware win over software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= DMRT_CONTROL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= sfr_wdata;
        ctrl_reg.unused <= 1'b0;
      end
      ctrl_reg.high_overflow_flag <= (wr_ctrl ? sfr_wdata[DMRT_BIT_HIGH_OVF]
        : ctrl_reg.high_overflow_flag) || wrap_high;
      ctrl_reg.low_overflow_flag <= (wr_ctrl ? sfr_wdata[DMRT_BIT_LOW_OVF]
        : ctrl_reg.low_overflow_flag) || wrap_low;
    end
  end

  // ==========================================================
  // interrupt request and read data
  // level request; software sees the overflow sources in the two flags, the capture request in none
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= extended_interrupt_enable && (ctrl_reg.high_overflow_flag
        || (ctrl_reg.low_interrupt_enable && ctrl_reg.low_overflow_flag) || cap_pend_reg);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        DMRT_ADDR_CONTROL: rdata_reg <= ctrl_reg & ~(8'h01 << DMRT_BIT_UNUSED);
        DMRT_ADDR_RELOAD_LOW: rdata_reg <= reload_low_reg;
        DMRT_ADDR_RELOAD_HIGH: rdata_reg <= reload_high_reg;
        DMRT_ADDR_COUNT_LOW: rdata_reg <= count_low_reg;
        DMRT_ADDR_COUNT_HIGH: rdata_reg <= count_high_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata = rdata_reg;
  assign timer_irq = irq_reg;

  // ==========================================================
  // assertions
  sequence s_full_wrap;
    wrap_full && !wr_cl && !wr_ch && !cap_evt;
  endsequence

  sequence s_ext_edge;
    $rose(ext_div8_clk) ##1 1'b1;
  endsequence

  a_full_reload: assert property (@(posedge clk) disable iff (rst)
    s_full_wrap |=> {count_high_reg, count_low_reg} == $past({reload_high_reg, reload_low_reg})
      && ctrl_reg.high_overflow_flag)
    else $error("full overflow did not reload or set high flag");

  a_low_flag_set: assert property (@(posedge clk) disable iff (rst)
    wrap_low |=> ctrl_reg.low_overflow_flag)
    else $error("low wrap did not set low flag");

  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg.high_overflow_flag && !wr_ctrl |=> ctrl_reg.high_overflow_flag)
    else $error("high flag cleared without software");

  a_split_low_runs: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg.split_mode && !ctrl_reg.run_control && low_byte_clock_mode && !wr_cl && !wr_ctrl
      && count_low_reg != DMRT_BYTE_ALL_ONES |=> count_low_reg == $past(count_low_reg) + 8'h01)
    else $error("low byte stalled in split mode");

  a_split_high_hold: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg.split_mode && !ctrl_reg.run_control && !wr_ch |=> $stable(count_high_reg))
    else $error("high byte moved without run");

  a_div12_period: assert property (@(posedge clk) disable iff (rst)
    tick12_reg |=> !tick12_reg [*8] ##1 !tick12_reg ##1 !tick12_reg ##1 !tick12_reg ##1 tick12_reg)
    else $error("divide by twelve tick period wrong");

  a_ext_sync_delay: assert property (@(posedge clk) disable iff (rst)
    s_ext_edge |=> ext_tick)
    else $error("external edge not seen after two stages");

  a_capture_copy: assert property (@(posedge clk) disable iff (rst)
    cap_evt |=> {reload_high_reg, reload_low_reg} == $past({count_high_reg, count_low_reg})
      ##1 (timer_irq || !extended_interrupt_enable))
    else $error("capture did not copy count or raise request");

  a_irq_gated: assert property (@(posedge clk) disable iff (rst)
    !extended_interrupt_enable |=> !timer_irq)
    else $error("request raised while disabled");

  a_irq_low_enable: assert property (@(posedge clk) disable iff (rst)
    extended_interrupt_enable && ctrl_reg.low_interrupt_enable && ctrl_reg.low_overflow_flag
      |=> timer_irq)
    else $error("low overflow request missing");

  a_unused_reads_zero: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && sfr_addr == DMRT_ADDR_CONTROL |=> !sfr_rdata[DMRT_BIT_UNUSED])
    else $error("unused control bit read as one");

  a_high_flag_set: assert property (@(posedge clk) disable iff (rst)
    wrap_high |=> ctrl_reg.high_overflow_flag)
    else $error("high wrap did not set high flag");

  a_low_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg.low_overflow_flag && !wr_ctrl |=> ctrl_reg.low_overflow_flag)
    else $error("low flag cleared without software");

  a_split_high_reload: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg.split_mode && wrap_high && !wr_ch |=> count_high_reg == $past(reload_high_reg))
    else $error("high byte did not reload from its reload byte");

  a_split_low_reload: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg.split_mode && wrap_low && !wr_cl |=> count_low_reg == $past(reload_low_reg))
    else $error("low byte did not reload from its reload byte");

  // a reload here would shorten every 16-bit period
  a_wide_low_carry: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg.split_mode && wrap_low && !wrap_high && !wr_cl |=> count_low_reg == DMRT_BYTE_RESET)
    else $error("low byte reloaded without full overflow");

  a_wide_high_step: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg.split_mode && wrap_low && !wrap_high && !wr_ch
      |=> count_high_reg == $past(count_high_reg) + 8'h01)
    else $error("carry did not step high byte");

  a_wide_stall: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg.split_mode && !ctrl_reg.run_control && !wr_cl |=> $stable(count_low_reg))
    else $error("16-bit counter moved without run");

  a_irq_high: assert property (@(posedge clk) disable iff (rst)
    extended_interrupt_enable && ctrl_reg.high_overflow_flag |=> timer_irq)
    else $error("high overflow request missing");

  a_irq_capture: assert property (@(posedge clk) disable iff (rst)
    extended_interrupt_enable && cap_pend_reg |=> timer_irq)
    else $error("capture request missing");

  a_sync_stages: assert property (@(posedge clk) disable iff (rst)
    ext_tick |-> $past(ext_div8_clk, 2) && !$past(ext_div8_clk, 3))
    else $error("external tick without a synchronised rising edge");

  a_count_low_write: assert property (@(posedge clk) disable iff (rst)
    wr_cl |=> count_low_reg == $past(sfr_wdata))
    else $error("low count write did not land");

  a_count_high_write: assert property (@(posedge clk) disable iff (rst)
    wr_ch |=> count_high_reg == $past(sfr_wdata))
    else $error("high count write did not land");

  a_reload_write: assert property (@(posedge clk) disable iff (rst)
    wr_rll && !cap_evt |=> reload_low_reg == $past(sfr_wdata))
    else $error("low reload write did not land");

  a_control_write: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl |=> ctrl_reg.split_mode == $past(sfr_wdata[DMRT_BIT_SPLIT])
      && ctrl_reg.run_control == $past(sfr_wdata[DMRT_BIT_RUN])
      && ctrl_reg.external_clock_select == $past(sfr_wdata[DMRT_BIT_EXT_SEL]))
    else $error("control write did not land");

endmodule : dmrt_timer
`default_nettype wire

// file: verification/dual_mode_reload_timer_tb.sv
/*
  self-checking testbench for the dual mode reload timer.
  assumes the sfr port contract of the design: one-cycle strobes, read data one edge later.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_mode_reload_timer_tb;
  import dmrt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, hmode = 1'b1, lmode = 1'b1;
  logic ext_clk = 1'b0, lfo = 1'b0, ien = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, got;
  wire logic [7:0] sfr_rdata;
  wire logic timer_irq;
  int failures = 0, num_checks = 0;

  dmrt_timer u_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .high_byte_clock_mode(hmode), .low_byte_clock_mode(lmode),
    .ext_div8_clk(ext_clk), .lfo_out(lfo), .extended_interrupt_enable(ien), .timer_irq(timer_irq));

  always #4 clk = ~clk;

  // ==========================================================
  // bus tasks and comparison
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    // read data stands until the next read, so this edge is race free
    @(posedge clk);
    got = sfr_rdata;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(got, e);
  endtask : rc
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, timer_irq}, {7'h00, e});
    // back onto an edge so that later stimulus stays edge aligned
    @(posedge clk);
  endtask : irq_is
  task automatic close_out;
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // ==========================================================
  // scenarios
  task automatic t_reset_and_layout;
    rc(DMRT_ADDR_CONTROL, 8'h00);
    rc(DMRT_ADDR_COUNT_LOW, 8'h00);
    rc(DMRT_ADDR_COUNT_HIGH, 8'h00);
    rc(DMRT_ADDR_RELOAD_HIGH, 8'h00);
    rc(8'h90, 8'h00);
    wr(DMRT_ADDR_CONTROL, 8'hFE);
    rc(DMRT_ADDR_CONTROL, 8'hFC);
    wr(DMRT_ADDR_CONTROL, 8'h00);
    rc(DMRT_ADDR_CONTROL, 8'h00);
  endtask : t_reset_and_layout

  task automatic t_wide_reload;
    wr(DMRT_ADDR_RELOAD_LOW, 8'h34);
    wr(DMRT_ADDR_RELOAD_HIGH, 8'h12);
    wr(DMRT_ADDR_COUNT_LOW, 8'hFE);
    wr(DMRT_ADDR_COUNT_HIGH, 8'hFF);
    rc(DMRT_ADDR_COUNT_LOW, 8'hFE);
    wr(DMRT_ADDR_CONTROL, 8'h04);
    repeat (20) @(posedge clk);
    rc(DMRT_ADDR_CONTROL, 8'hC4);
    ien <= 1'b1;
    irq_is(1'b1);
    ien <= 1'b0;
    irq_is(1'b0);
    wr(DMRT_ADDR_CONTROL, 8'h00);
    rc(DMRT_ADDR_COUNT_HIGH, 8'h12);
    rc(DMRT_ADDR_RELOAD_LOW, 8'h34);
    // low wrap alone: low flag and carry into high byte
    wr(DMRT_ADDR_COUNT_HIGH, 8'h00);
    wr(DMRT_ADDR_COUNT_LOW, 8'hFE);
    ien <= 1'b1;
    wr(DMRT_ADDR_CONTROL, 8'h24);
    repeat (6) @(posedge clk);
    rc(DMRT_ADDR_CONTROL, 8'h64);
    irq_is(1'b1);
    rc(DMRT_ADDR_CONTROL, 8'h64);
    wr(DMRT_ADDR_CONTROL, 8'h40);
    irq_is(1'b0);
    rc(DMRT_ADDR_COUNT_HIGH, 8'h01);
    // a lone low wrap carries through zero instead of reloading 8'h34
    rd(DMRT_ADDR_COUNT_LOW);
    chk((got < 8'h20) ? 8'h00 : got, 8'h00);
    wr(DMRT_ADDR_CONTROL, 8'h00);
  endtask : t_wide_reload

  task automatic t_split;
    wr(DMRT_ADDR_RELOAD_LOW, 8'h10);
    wr(DMRT_ADDR_RELOAD_HIGH, 8'h20);
    wr(DMRT_ADDR_COUNT_LOW, 8'hFF);
    wr(DMRT_ADDR_COUNT_HIGH, 8'hFF);
    wr(DMRT_ADDR_CONTROL, 8'h08);
    repeat (4) @(posedge clk);
    rc(DMRT_ADDR_COUNT_HIGH, 8'hFF);
    rc(DMRT_ADDR_CONTROL, 8'h48);
    irq_is(1'b0);
    rd(DMRT_ADDR_COUNT_LOW);
    chk(got & 8'hF0, 8'h10);
    wr(DMRT_ADDR_CONTROL, 8'h4C);
    repeat (4) @(posedge clk);
    rc(DMRT_ADDR_CONTROL, 8'hCC);
    irq_is(1'b1);
    rd(DMRT_ADDR_COUNT_HIGH);
    chk(got & 8'hF0, 8'h20);
    ien <= 1'b0;
    wr(DMRT_ADDR_CONTROL, 8'h00);
  endtask : t_split

  task automatic t_clock_sources;
    hmode <= 1'b0;
    lmode <= 1'b0;
    wr(DMRT_ADDR_COUNT_LOW, 8'h00);
    wr(DMRT_ADDR_COUNT_HIGH, 8'h00);
    // split mode so both byte selections run on the divide by twelve tick
    wr(DMRT_ADDR_CONTROL, 8'h0C);
    repeat (120) @(posedge clk);
    wr(DMRT_ADDR_CONTROL, 8'h00);
    rd(DMRT_ADDR_COUNT_LOW);
    // prescaler phase is free, so one tick either way
    chk((got >= 8'h09 && got <= 8'h0B) ? 8'h0A : got, 8'h0A);
    rd(DMRT_ADDR_COUNT_HIGH);
    chk((got >= 8'h09 && got <= 8'h0B) ? 8'h0A : got, 8'h0A);
    wr(DMRT_ADDR_COUNT_LOW, 8'h00);
    wr(DMRT_ADDR_CONTROL, 8'h05);
    repeat (5) begin
      ext_clk <= 1'b1;
      repeat (8) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (8) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    wr(DMRT_ADDR_CONTROL, 8'h01);
    rc(DMRT_ADDR_COUNT_LOW, 8'h05);
    hmode <= 1'b1;
    lmode <= 1'b1;
  endtask : t_clock_sources

  task automatic t_capture;
    wr(DMRT_ADDR_CONTROL, 8'h10);
    wr(DMRT_ADDR_COUNT_LOW, 8'h78);
    wr(DMRT_ADDR_COUNT_HIGH, 8'h56);
    ien <= 1'b1;
    lfo <= 1'b1;
    repeat (3) @(posedge clk);
    rc(DMRT_ADDR_RELOAD_LOW, 8'h78);
    rc(DMRT_ADDR_RELOAD_HIGH, 8'h56);
    irq_is(1'b1);
    lfo <= 1'b0;
    wr(DMRT_ADDR_CONTROL, 8'h00);
    irq_is(1'b0);
  endtask : t_capture

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_and_layout();
    t_wide_reload();
    t_split();
    t_clock_sources();
    t_capture();
    close_out();
  end
  // the run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule : dual_mode_reload_timer_tb
`default_nettype wire
